//--- rtl/srl_pkg.sv
// constants for the receive latency path
package srl_pkg;
    // ========================================
    // latency figures
    localparam int PCLK_BIT_DIV = 40;
    localparam int FIXED_LAT_PCLK = 12;
    localparam int VAR_LAT_PCLK = 2;
    localparam int IFACE_LAT_PCLK = 1;
    localparam int DP_DELAY_CLK = 48;
    localparam int LMFC_DELAY_CLK = 4;
    localparam int SYSREF_DIV = 4;
    localparam int CLK_PERIOD_NS = 8;
    // ========================================
    // status word indices of the captured phase and capture count
    localparam logic [11:0] STAT_PHASE_IDX = 12'h037;
    localparam logic [11:0] STAT_COUNT_IDX = 12'h038;
    localparam logic [3:0] MIN_INTERP_DBL = 4'h2;
    localparam int LINK_STAGES = FIXED_LAT_PCLK + VAR_LAT_PCLK
        + IFACE_LAT_PCLK;
endpackage : srl_pkg

//--- rtl/srl_skid_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module srl_skid_buf #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem_ff [2];
    logic rdPtr_ff;
    logic wrPtr_ff;
    logic [1:0] count_ff;
    logic [1:0] nxt_count;
    logic inRdy_ff;
    logic push;
    logic pop;

    // ready is registered so the link side sees a flop, not a compare
    assign inReady = inRdy_ff;
    assign nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
    assign outValid = (count_ff != 2'h0);
    assign outData = mem_ff[rdPtr_ff];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem_ff[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rdPtr_ff <= 1'b0;
            wrPtr_ff <= 1'b0;
            count_ff <= 2'h0;
            inRdy_ff <= 1'b1;
        end
        else
        begin
            if (push)
            begin
                wrPtr_ff <= ~wrPtr_ff;
            end
            if (pop)
            begin
                rdPtr_ff <= ~rdPtr_ff;
            end
            count_ff <= nxt_count;
            inRdy_ff <= (nxt_count != 2'h2);
        end
    end
endmodule : srl_skid_buf

//--- rtl/srl_rx_latency.sv
// receive path timing: processing tick, latency pipes, SYSREF and LMFC
`timescale 1ns/100ps
module srl_rx_latency #(
    parameter int WIDTH = 32,
    parameter int LANE_BITS_PER_CLK = 4,
    parameter int LMFC_PERIOD = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // deframed samples from the link
    input wire logic linkValid,
    output logic linkReady,
    input wire logic [WIDTH-1:0] linkData,
    input wire logic [1:0] laneSkew,
    // datapath configuration
    input wire logic dblRateEn,
    input wire logic [3:0] interpFactor,
    // timing reference
    input wire logic sysref,
    // samples to the converter
    output logic dacValid,
    output logic [WIDTH-1:0] dacData,
    output logic dacRate2x,
    output logic cfgError,
    // status
    output logic pclkTick,
    output logic lmfcPulse,
    output logic [5:0] latencyPclk,
    output logic [11:0] statPhaseIdx,
    output logic [1:0] statPhase,
    output logic [11:0] statCountIdx,
    output logic [7:0] statCount
);
    // ========================================
    // processing clock tick
    localparam logic [7:0] BITS_STEP = 8'(LANE_BITS_PER_CLK);
    localparam logic [7:0] BITS_DIV = 8'(srl_pkg::PCLK_BIT_DIV);
    logic [7:0] bitAcc_ff;
    logic tick_ff;
    logic [7:0] accSum;

    assign accSum = bitAcc_ff + BITS_STEP;

    // accumulate lane bits; one tick per forty bits
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bitAcc_ff <= 8'h00;
            tick_ff <= 1'b0;
        end
        else if (accSum >= BITS_DIV)
        begin
            bitAcc_ff <= accSum - BITS_DIV;
            tick_ff <= 1'b1;
        end
        else
        begin
            bitAcc_ff <= accSum;
            tick_ff <= 1'b0;
        end
    end
    assign pclkTick = tick_ff;

    // ========================================
    // input buffer drained once per tick
    logic bufValid;
    logic [WIDTH-1:0] bufData;

    srl_skid_buf #(
        .WIDTH(WIDTH)
    ) u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .inValid(linkValid),
        .inReady(linkReady),
        .inData(linkData),
        .outValid(bufValid),
        .outReady(tick_ff),
        .outData(bufData)
    );

    // ========================================
    // link and hand-over pipe in processing clocks
    localparam int LS = srl_pkg::LINK_STAGES;
    logic [WIDTH-1:0] linkPipe_ff [LS];
    logic [LS-1:0] linkVld_ff;
    logic [1:0] skewSel;
    int tapIdx;

    // skew beyond the variable allowance is clamped into it
    assign skewSel = (laneSkew > 2'(srl_pkg::VAR_LAT_PCLK)) ?
        2'(srl_pkg::VAR_LAT_PCLK) : laneSkew;
    assign tapIdx = srl_pkg::FIXED_LAT_PCLK + int'(skewSel)
        + srl_pkg::IFACE_LAT_PCLK - 1;

    genvar gi;
    generate
        for (gi = 0; gi < LS; gi++)
        begin : g_link
            localparam int PREV = (gi == 0) ? 0 : gi - 1;
            always_ff @(posedge ref_clk)
            begin
                if (rst)
                begin
                    linkVld_ff[gi] <= 1'b0;
                    linkPipe_ff[gi] <= '0;
                end
                else if (tick_ff)
                begin
                    // fixed 12, variable up to 2, hand-over 1
                    linkVld_ff[gi] <= (gi == 0) ? bufValid : linkVld_ff[PREV];
                    linkPipe_ff[gi] <= (gi == 0) ? bufData : linkPipe_ff[PREV];
                end
            end
        end
    endgenerate

    // ========================================
    // datapath pipe in sample clocks
    localparam int DP = srl_pkg::DP_DELAY_CLK;
    logic [WIDTH-1:0] dpPipe_ff [DP];
    logic [DP-1:0] dpVld_ff;
    logic dpIn;

    // the tap is fresh only in the cycle that follows a tick
    logic tickD_ff;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            tickD_ff <= 1'b0;
        end
        else
        begin
            tickD_ff <= tick_ff;
        end
    end
    assign dpIn = tickD_ff && linkVld_ff[tapIdx];

    generate
        for (gi = 0; gi < DP; gi++)
        begin : g_dp
            localparam int PREV = (gi == 0) ? 0 : gi - 1;
            always_ff @(posedge ref_clk)
            begin
                if (rst)
                begin
                    dpVld_ff[gi] <= 1'b0;
                    dpPipe_ff[gi] <= '0;
                end
                else
                begin
                    // 48 sample clocks, nco only
                    dpVld_ff[gi] <= (gi == 0) ? dpIn : dpVld_ff[PREV];
                    dpPipe_ff[gi] <= (gi == 0) ? linkPipe_ff[tapIdx]
                        : dpPipe_ff[PREV];
                end
            end
        end
    endgenerate
    assign dacValid = dpVld_ff[DP-1];
    assign dacData = dpPipe_ff[DP-1];

    // ========================================
    // configuration and latency report
    logic rate2x_ff;
    logic cfgErr_ff;
    logic [5:0] latPclk_ff;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rate2x_ff <= 1'b0;
            cfgErr_ff <= 1'b0;
            latPclk_ff <= 6'h00;
        end
        else
        begin
            rate2x_ff <= dblRateEn;
            cfgErr_ff <= dblRateEn
                && (interpFactor < srl_pkg::MIN_INTERP_DBL);
            // link share in pclk cycles; datapath adds 48 sample clocks
            latPclk_ff <= 6'(tapIdx + 1);
        end
    end
    assign dacRate2x = rate2x_ff;
    assign cfgError = cfgErr_ff;
    assign latencyPclk = latPclk_ff;

    // ========================================
    // SYSREF sampling and phase capture
    localparam int SYSREF_LAST = srl_pkg::SYSREF_DIV - 1;
    logic [1:0] sampPh_ff;
    logic [3:0] hist_ff;
    logic sampled_ff;
    logic hit_ff;
    logic [1:0] phase_ff;
    logic [7:0] count_ff;
    logic [1:0] firstHigh;
    logic [3:0] histNow;

    assign histNow = {sysref, hist_ff[3:1]};
    always_comb
    begin
        firstHigh = 2'h3;
        for (int i = 3; i >= 0; i--)
        begin
            if (histNow[i])
            begin
                firstHigh = 2'(i);
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sampPh_ff <= 2'h0;
            hist_ff <= 4'h0;
            sampled_ff <= 1'b0;
            hit_ff <= 1'b0;
            phase_ff <= 2'h0;
            count_ff <= 8'h00;
        end
        else
        begin
            sampPh_ff <= sampPh_ff + 2'h1;
            hist_ff <= histNow;
            hit_ff <= 1'b0;
            // one sample per four sample clocks
            if (sampPh_ff == 2'(SYSREF_LAST))
            begin
                sampled_ff <= sysref;
                if (sysref && !sampled_ff)
                begin
                    hit_ff <= 1'b1;
                    phase_ff <= firstHigh;
                    count_ff <= count_ff + 8'h01;
                end
            end
        end
    end
    assign statPhaseIdx = srl_pkg::STAT_PHASE_IDX;
    assign statPhase = phase_ff;
    assign statCountIdx = srl_pkg::STAT_COUNT_IDX;
    assign statCount = count_ff;

    // ========================================
    // LMFC with delayed realignment
    logic [2:0] alignCnt_ff;
    logic [7:0] lmfc_ff;
    logic lmfcP_ff;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            alignCnt_ff <= 3'h0;
            lmfc_ff <= 8'h00;
            lmfcP_ff <= 1'b0;
        end
        else
        begin
            lmfcP_ff <= 1'b0;
            lmfc_ff <= (lmfc_ff == 8'(LMFC_PERIOD - 1)) ? 8'h00
                : lmfc_ff + 8'h01;
            if (lmfc_ff == 8'(LMFC_PERIOD - 1))
            begin
                lmfcP_ff <= 1'b1;
            end
            if (hit_ff)
            begin
                alignCnt_ff <= 3'(srl_pkg::LMFC_DELAY_CLK - 1);
            end
            else if (alignCnt_ff != 3'h0)
            begin
                alignCnt_ff <= alignCnt_ff - 3'h1;
                if (alignCnt_ff == 3'h1)
                begin
                    // realign 4 clocks after detection
                    lmfc_ff <= 8'h00;
                    lmfcP_ff <= 1'b1;
                end
            end
        end
    end
    assign lmfcPulse = lmfcP_ff;

    // ========================================
    // checks
    property p_tick_gap;
        @(posedge ref_clk) disable iff (rst)
        tick_ff |=> !tick_ff;
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("tick too close");

    property p_dp_delay;
        @(posedge ref_clk) disable iff (rst)
        dpIn |-> ##48 dacValid;
    endproperty
    a_dp_delay: assert property (p_dp_delay)
        else $error("datapath delay");

    property p_dp_data;
        @(posedge ref_clk) disable iff (rst)
        dpIn |-> ##48 (dacData == $past(linkPipe_ff[tapIdx], 48));
    endproperty
    a_dp_data: assert property (p_dp_data)
        else $error("datapath data");

    property p_lmfc_align;
        @(posedge ref_clk) disable iff (rst)
        hit_ff |-> ##4 (lmfcP_ff && lmfc_ff == 8'h00);
    endproperty
    a_lmfc_align: assert property (p_lmfc_align)
        else $error("lmfc late");

    property p_sample_rate;
        @(posedge ref_clk) disable iff (rst)
        hit_ff |=> !hit_ff ##1 !hit_ff ##1 !hit_ff;
    endproperty
    a_sample_rate: assert property (p_sample_rate)
        else $error("sysref rate");

    property p_phase_cap;
        @(posedge ref_clk) disable iff (rst)
        hit_ff |-> (statCount == $past(statCount) + 8'h01);
    endproperty
    a_phase_cap: assert property (p_phase_cap)
        else $error("capture count");

    property p_cfg_err;
        @(posedge ref_clk) disable iff (rst)
        (dblRateEn && interpFactor < 4'h2) |=> cfgError && dacRate2x;
    endproperty
    a_cfg_err: assert property (p_cfg_err)
        else $error("double rate check");

    property p_link_lat;
        @(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> (latencyPclk == (($past(laneSkew) == 2'h3) ? 6'd15
            : 6'd13 + {4'h0, $past(laneSkew)}));
    endproperty
    a_link_lat: assert property (p_link_lat)
        else $error("link latency");

    property p_handover;
        @(posedge ref_clk) disable iff (rst)
        (tick_ff && linkVld_ff[tapIdx - 1]) |=> dpIn;
    endproperty
    a_handover: assert property (p_handover)
        else $error("hand-over");
endmodule : srl_rx_latency

//--- sim/srl_tx_model.sv
// transmitter model feeding deframed words into the receive path
`timescale 1ns/100ps
module srl_tx_model #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // pacing from the bench
    input wire logic holdOff,
    // link side
    input wire logic linkReady,
    output logic linkValid,
    output logic [WIDTH-1:0] linkData,
    output logic taken
);
    logic [WIDTH-1:0] pend[$];
    initial
    begin
        linkValid = 1'b0;
        linkData = '0;
        taken = 1'b0;
    end
    always @(posedge ref_clk)
        taken <= linkValid && linkReady && !rst;
    // at most one word per clock keeps the rate band
    always @(negedge ref_clk)
    begin
        if (taken || !linkValid)
        begin
            if (pend.size() > 0 && !holdOff)
            begin
                linkValid <= 1'b1;
                linkData <= pend.pop_front();
            end
            else if (linkValid)
            begin
                // released data must not look like the last word
                linkValid <= 1'b0;
                linkData <= ~linkData;
            end
        end
    end
endmodule : srl_tx_model

//--- sim/srl_rx_latency_tb.sv
// self-checking bench for the receive latency path
`timescale 1ns/100ps
module srl_rx_latency_tb;
    logic ref_clk, rst, linkValid, linkReady, dblRateEn, sysref, taken;
    logic dacValid, dacRate2x, cfgError, pclkTick, lmfcPulse, holdOff;
    logic [31:0] linkData, dacData;
    logic [1:0] laneSkew, statPhase;
    logic [3:0] interpFactor;
    logic [5:0] latencyPclk;
    logic [11:0] statPhaseIdx, statCountIdx;
    logic [7:0] statCount, prevCount;
    logic [15:0] lfsrVal;
    logic [31:0] expq[$];
    int mismatches, checks_done, cycles, tLast, tAcc, tOut, outCount;
    int refused, lmfcAge, lmfcSeen, target, s, i, lo;

    srl_rx_latency DUT (.ref_clk(ref_clk), .rst(rst),
        .linkValid(linkValid), .linkReady(linkReady), .linkData(linkData),
        .laneSkew(laneSkew), .dblRateEn(dblRateEn),
        .interpFactor(interpFactor), .sysref(sysref), .dacValid(dacValid),
        .dacData(dacData), .dacRate2x(dacRate2x), .cfgError(cfgError),
        .pclkTick(pclkTick), .lmfcPulse(lmfcPulse),
        .latencyPclk(latencyPclk), .statPhaseIdx(statPhaseIdx),
        .statPhase(statPhase), .statCountIdx(statCountIdx),
        .statCount(statCount));
    srl_tx_model txm (.ref_clk(ref_clk), .rst(rst), .holdOff(holdOff),
        .linkReady(linkReady), .linkValid(linkValid), .linkData(linkData),
        .taken(taken));

    // ========================================
    // helpers
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    task automatic wait_out;
        for (int w = 0; w < 2000 && outCount < target; w++)
            @(negedge ref_clk);
        chk(outCount >= target, 1);
    endtask : wait_out

    // ========================================
    // clock, timeout and monitors
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            test_done();
        end
        // the note is taken at the accepting edge, from the stimulus
        if (!rst && linkValid && linkReady)
            expq.push_back(linkData);
    end
    always @(negedge ref_clk)
    begin
        if (taken)
            tAcc = cycles;
        if (linkValid && !linkReady)
            refused++;
        if (!rst && pclkTick)
        begin
            if (tLast > 0)
                chk(cycles - tLast, 10);
            tLast = cycles;
        end
        if (dacValid)
        begin
            if (expq.size() == 0)
                chk(32'h1, 32'h0);
            else
                chk(dacData, expq.pop_front());
            tOut = cycles;
            outCount++;
        end
        lmfcAge = (statCount !== prevCount) ? 0 : lmfcAge + 1;
        prevCount = statCount;
        if (lmfcPulse && lmfcAge == 4)
            lmfcSeen++;
    end

    // ========================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        holdOff = 1'b0;
        laneSkew = 2'h0;
        dblRateEn = 1'b0;
        interpFactor = 4'h1;
        sysref = 1'b0;
        lfsrVal = 16'hee52;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk(statPhaseIdx, 12'h037);
        chk(statCountIdx, 12'h038);
        chk(statCount, 8'h00);
        // single words with each lane skew, 3 clamps to 2
        for (s = 0; s < 4; s++)
        begin
            laneSkew = s[1:0];
            repeat (2) @(negedge ref_clk);
            lo = (s > 2) ? 2 : s;
            chk(latencyPclk, 6'(12 + lo + 1));
            lfsrVal = lfsr(lfsrVal);
            txm.pend.push_back({lfsrVal, ~lfsrVal});
            target = outCount + 1;
            wait_out();
            // the tick that drains the buffer is the first of the 13+skew
            lo = (12 + lo) * 10 + 49;
            chk((tOut - tAcc >= lo) && (tOut - tAcc <= lo + 9), 1);
        end
        $display("latency tests done");
        // burst with random pacing fills the buffer until it refuses
        refused = 0;
        for (i = 0; i < 8; i++)
        begin
            lfsrVal = lfsr(lfsrVal);
            txm.pend.push_back({~lfsrVal, lfsrVal});
        end
        target = outCount + 8;
        for (i = 0; i < 60; i++)
        begin
            @(negedge ref_clk);
            lfsrVal = lfsr(lfsrVal);
            holdOff = lfsrVal[0] & lfsrVal[3];
        end
        holdOff = 1'b0;
        wait_out();
        chk(refused > 0, 1);
        chk(expq.size(), 0);
        $display("burst test done");
        // double-rate mode and its interpolation floor
        for (i = 0; i < 8; i++)
        begin
            dblRateEn = i[2];
            interpFactor = {2'h0, i[1:0]};
            repeat (2) @(negedge ref_clk);
            chk(dacRate2x, i[2]);
            chk(cfgError, i[2] && (i[1:0] < 2));
        end
        $display("config test done");
        // three timing reference pulses
        lmfcSeen = 0;
        for (i = 0; i < 3; i++)
        begin
            sysref = 1'b1;
            // phase is the first raw cycle of the window that saw it high
            lo = (cycles + 1) % 4;
            repeat (8) @(negedge ref_clk);
            chk(statPhase, lo);
            sysref = 1'b0;
            repeat (40) @(negedge ref_clk);
        end
        chk(statCount, 8'h03);
        chk(lmfcSeen, 3);
        $display("reference test done");
        test_done();
    end
endmodule : srl_rx_latency_tb
